// *** logic/mbch_pkg.sv ***
// constants and types shared by the modbus coil and register handler
//
// Notes on behaviour
// - read coils (01) is never broadcast; a broadcast read gets no action
// - wire address is item number minus one; first item is address zero
// - read coils reply packs one coil per bit, one is on
// - first coil goes to lsb of first byte, then upward
// - unused high bits of the last coil byte read as zero
// - read coils reply: address, function, byte count, data, crc
// - function 05 forces one coil; broadcast forces it too
// - force data ff 00 is on, 00 00 is off
// - coil 65 at wire address 64 is the write-control coil
// - single coil reply echoes the query after the coil is forced
// - function 0f: start, quantity, byte count, packed data, crc
// - multiple coil reply: address, function, start, quantity, crc
// - function 03 query: start hi/lo, quantity hi/lo, crc
// - register reply: byte count then high byte, low byte per register
// - a 32-bit parameter spans two registers, read with quantity two
// - function 06 query: register address hi/lo, data hi/lo, crc
// - single register reply echoes query after the data is passed on
// - holding register number is ten times the parameter number
// - write-control coil one stores to nonvolatile and ram, zero ram only
// - unsupported function code answers with exception code 1
`default_nettype none

package mbch_pkg;

  // function codes
  localparam logic [7:0]  FC_READ_COILS  = 8'h01;
  localparam logic [7:0]  FC_READ_REGS   = 8'h03;
  localparam logic [7:0]  FC_WRITE_COIL  = 8'h05;
  localparam logic [7:0]  FC_WRITE_REG   = 8'h06;
  localparam logic [7:0]  FC_WRITE_COILS = 8'h0F;

  // exception answers
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_NONE       = 8'h00;
  localparam logic [7:0]  EXC_FUNC       = 8'h01;
  localparam logic [7:0]  EXC_ADDR       = 8'h02;
  localparam logic [7:0]  EXC_VALUE      = 8'h03;

  // addressing
  localparam logic [7:0]  BCAST_ADDR     = 8'h00;
  localparam int          COIL_COUNT     = 128;
  localparam logic [16:0] COIL_LIMIT     = 17'h0_0080;
  localparam logic [6:0]  WR_CTRL_COIL   = 7'h40;
  localparam int          STATUS_BASE    = 32;
  localparam logic [15:0] COIL_ON        = 16'hFF00;
  localparam logic [15:0] COIL_OFF       = 16'h0000;
  localparam logic [15:0] MAX_RD_COILS   = 16'h07D0;
  localparam logic [15:0] MAX_WR_COILS   = 16'h07B0;
  localparam logic [15:0] MAX_RD_REGS    = 16'h007D;
  localparam logic [16:0] PARAM_STEP     = 17'h0_000A;

  // frame buffer and frame lengths
  localparam int          BUF_DEPTH      = 256;
  localparam logic [8:0]  MIN_FRAME      = 9'h004;
  localparam logic [8:0]  FIXED_FRAME    = 9'h008;
  localparam logic [8:0]  WR_COILS_OVH   = 9'h009;
  localparam logic [7:0]  WR_COILS_DATA  = 8'h07;
  localparam logic [8:0]  ECHO_LEN       = 9'h006;
  localparam logic [8:0]  EXC_LEN        = 9'h003;
  localparam logic [7:0]  RD_HDR_LEN     = 8'h03;

  // crc-16 of the serial line
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] CRC_GOOD       = 16'h0000;

  // handler states
  typedef enum logic [3:0] {
    ST_RX, ST_DECODE, ST_COIL_RD, ST_COIL_WR, ST_REG_RD, ST_REG_WR,
    ST_TX, ST_TX_HI, ST_TX_END
  } mbch_state_t;

endpackage

`default_nettype wire

// *** logic/mbch_crc_if.sv ***
// byte stream into a crc engine and the running crc back
`timescale 1ns/1ps
`default_nettype none

interface mbch_crc_if;
  logic        clear;
  logic        valid;
  logic [7:0]  data;
  logic [15:0] crc;

  modport eng  (input clear, input valid, input data, output crc);
  modport user (output clear, output valid, output data, input crc);
endinterface

`default_nettype wire

// *** logic/mbch_crc.sv ***
// crc-16 engine, one byte a clock
`timescale 1ns/1ps
`default_nettype none

module mbch_crc
  import mbch_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  // byte stream
  mbch_crc_if.eng    crc_if
);

  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;

  // eight shift steps of the reflected polynomial
  always_comb
  begin
    nxt_crc = crc_ff ^ {8'h00, crc_if.data};
    for (int b = 0; b < 8; b++)
    begin
      nxt_crc = nxt_crc[0] ? ((nxt_crc >> 1) ^ CRC_POLY) : (nxt_crc >> 1);
    end
  end

  // clear wins over a byte in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (reset_i || crc_if.clear)
      crc_ff <= CRC_INIT;
    else if (crc_if.valid)
      crc_ff <= nxt_crc;
  end

  assign crc_if.crc = crc_ff;

endmodule // mbch_crc

`default_nettype wire

// *** logic/mbch_handler.sv ***
// modbus rtu server for coils and holding registers
`timescale 1ns/1ps
`default_nettype none

module mbch_handler
  import mbch_pkg::*;
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // own station address
  input  wire logic [7:0]    own_addr_i,
  // received frame bytes
  input  wire logic [7:0]    rx_byte_i,
  input  wire logic          rx_valid_i,
  input  wire logic          rx_end_i,
  output logic               rx_busy_o,
  // reply bytes
  output logic [7:0]         tx_byte_o,
  output logic               tx_valid_o,
  input  wire logic          tx_ready_i,
  output logic               tx_done_o,
  // coils seen by the drive
  input  wire logic [15:0]   drive_status_word_i,
  output logic [COIL_COUNT-1:0] coils_o,
  output logic               nv_store_o,
  // parameter access
  output logic               par_rd_req_o,
  output logic               par_wr_req_o,
  output logic [15:0]        par_addr_o,
  output logic [15:0]        par_num_o,
  output logic [15:0]        par_wr_data_o,
  input  wire logic          par_ack_i,
  input  wire logic [15:0]   par_rd_data_i
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  mbch_state_t               state_ff;
  logic [7:0]                rx_buf [0:BUF_DEPTH-1];
  logic [7:0]                tx_buf [0:BUF_DEPTH-1];
  logic [8:0]                rx_len_ff;
  logic                      rx_ovf_ff;
  logic [8:0]                frame_len_ff;
  logic                      bcast_ff;
  logic                      echo_ff;
  logic [10:0]               cnt_ff;
  logic [8:0]                tx_len_ff;
  logic [8:0]                tx_idx_ff;
  logic [7:0]                tx_byte_ff;
  logic                      tx_valid_ff;
  logic                      tx_done_ff;
  logic                      rd_req_ff;
  logic                      wr_req_ff;
  logic [15:0]               par_addr_ff;
  logic [15:0]               par_num_ff;
  logic [15:0]               wr_data_ff;
  logic [15:0]               nxt_par_addr;
  logic [COIL_COUNT-1:0]     coil_ff;
  logic [COIL_COUNT-1:0]     coil_view;
  logic                      coil_we;
  logic [6:0]                coil_idx;
  logic                      coil_val;
  logic [7:0]                fc;
  logic [15:0]               start;
  logic [15:0]               qty;
  logic [7:0]                bcnt;
  logic [16:0]               coil_end;
  logic [15:0]               qty_bytes;
  logic [7:0]                exc;
  logic                      frame_ok;
  logic                      send_ok;
  logic [7:0]                tx_src;
  logic [7:0]                coil_byte;
  logic [10:0]               last_cnt;

  mbch_crc_if rx_crc ();
  mbch_crc_if tx_crc ();

  ////////////////////////////////////////////////////////////////////////////
  // crc engines for query and reply

  mbch_crc u_rx_crc
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .crc_if  (rx_crc)
  );

  mbch_crc u_tx_crc
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .crc_if  (tx_crc)
  );

  // query bytes feed the check while collecting
  assign rx_crc.clear = rx_end_i;
  assign rx_crc.valid = (state_ff == ST_RX) && rx_valid_i && !rx_end_i;
  assign rx_crc.data  = rx_byte_i;

  // reply bytes feed the appended crc
  assign tx_crc.clear = (state_ff == ST_RX);
  assign tx_crc.valid = (state_ff == ST_TX) && send_ok && (tx_idx_ff < tx_len_ff);
  assign tx_crc.data  = tx_src;

  ////////////////////////////////////////////////////////////////////////////
  // query capture

  // bytes are taken only while idle; the buffer holds still while busy
  always_ff @(posedge clk_i)
  begin
    if (reset_i || rx_end_i)
    begin
      rx_len_ff <= 9'h000;
      rx_ovf_ff <= 1'b0;
    end
    else if ((state_ff == ST_RX) && rx_valid_i)
    begin
      if (rx_len_ff == 9'(BUF_DEPTH))
        rx_ovf_ff <= 1'b1;
      else
      begin
        rx_buf[rx_len_ff[7:0]] <= rx_byte_i;
        rx_len_ff <= rx_len_ff + 9'h001;
      end
    end
  end

  // crc residue of zero over data plus crc means a clean frame
  assign frame_ok = (rx_len_ff >= MIN_FRAME) && !rx_ovf_ff
                 && (rx_crc.crc == CRC_GOOD)
                 && ((rx_buf[0] == own_addr_i) || (rx_buf[0] == BCAST_ADDR));

  ////////////////////////////////////////////////////////////////////////////
  // query fields and checks

  assign fc        = rx_buf[1];
  assign start     = {rx_buf[2], rx_buf[3]};
  assign qty       = {rx_buf[4], rx_buf[5]};
  assign bcnt      = rx_buf[6];
  assign coil_end  = {1'b0, start} + {1'b0, qty};
  assign qty_bytes = 16'(({1'b0, qty} + 17'h0_0007) >> 3);

  // exception code for the received query, zero when it is acceptable
  always_comb
  begin
    exc = EXC_NONE;
    case (fc)
      FC_READ_COILS:
      begin
        if (frame_len_ff != FIXED_FRAME || qty == 16'h0000 || qty > MAX_RD_COILS)
          exc = EXC_VALUE;
        else if (coil_end > COIL_LIMIT)
          exc = EXC_ADDR;
      end
      FC_WRITE_COIL:
      begin
        if (frame_len_ff != FIXED_FRAME || (qty != COIL_ON && qty != COIL_OFF))
          exc = EXC_VALUE;
        else if ({1'b0, start} >= COIL_LIMIT)
          exc = EXC_ADDR;
      end
      FC_WRITE_COILS:
      begin
        if (qty == 16'h0000 || qty > MAX_WR_COILS || {8'h00, bcnt} != qty_bytes
            || frame_len_ff != WR_COILS_OVH + {1'b0, bcnt})
          exc = EXC_VALUE;
        else if (coil_end > COIL_LIMIT)
          exc = EXC_ADDR;
      end
      FC_READ_REGS:
      begin
        if (frame_len_ff != FIXED_FRAME || qty == 16'h0000 || qty > MAX_RD_REGS)
          exc = EXC_VALUE;
      end
      FC_WRITE_REG:
      begin
        if (frame_len_ff != FIXED_FRAME)
          exc = EXC_VALUE;
      end
      default: exc = EXC_FUNC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // coil image

  // status word coils 33..48 show the drive state, the rest are stored
  always_comb
  begin
    coil_view = coil_ff;
    for (int b = 0; b < 16; b++)
    begin
      coil_view[STATUS_BASE + b] = drive_status_word_i[b];
    end
  end

  // one read byte: first coil in the lsb, zero past the quantity
  always_comb
  begin
    coil_byte = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      if ({cnt_ff[7:0], 3'(k)} < 11'(qty))
        coil_byte[k] = coil_view[7'(start) + {cnt_ff[3:0], 3'(k)}];
    end
  end

  // single coil forced at decode, multiple coils one per cycle
  always_comb
  begin
    coil_we  = 1'b0;
    coil_idx = start[6:0];
    coil_val = rx_buf[4][7];
    if (state_ff == ST_DECODE && fc == FC_WRITE_COIL && exc == EXC_NONE)
      coil_we = 1'b1;
    else if (state_ff == ST_COIL_WR)
    begin
      coil_we  = 1'b1;
      coil_idx = start[6:0] + cnt_ff[6:0];
      coil_val = rx_buf[WR_COILS_DATA + 8'(cnt_ff[10:3])][cnt_ff[2:0]];
    end
  end

  // stored coils, broadcast writes land here too
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      coil_ff <= '0;
    else if (coil_we)
      coil_ff[coil_idx] <= coil_val;
  end

  assign coils_o    = coil_ff;
  assign nv_store_o = coil_ff[WR_CTRL_COIL];

  ////////////////////////////////////////////////////////////////////////////
  // parameter address and number

  // register address advances after each answered read word
  always_comb
  begin
    nxt_par_addr = par_addr_ff;
    if (state_ff == ST_DECODE)
      nxt_par_addr = start;
    else if (state_ff == ST_REG_RD && par_ack_i)
      nxt_par_addr = par_addr_ff + 16'h0001;
  end

  // register number is address plus one; parameter is that over ten
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      par_addr_ff <= 16'h0000;
      par_num_ff  <= 16'h0000;
    end
    else
    begin
      par_addr_ff <= nxt_par_addr;
      par_num_ff  <= 16'(({1'b0, nxt_par_addr} + 17'h0_0001) / PARAM_STEP);
    end
  end

  assign par_addr_o    = par_addr_ff;
  assign par_num_o     = par_num_ff;
  assign par_wr_data_o = wr_data_ff;
  assign par_rd_req_o  = rd_req_ff;
  assign par_wr_req_o  = wr_req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign send_ok  = !tx_valid_ff || tx_ready_i;
  assign tx_src   = echo_ff ? rx_buf[tx_idx_ff[7:0]] : tx_buf[tx_idx_ff[7:0]];
  assign last_cnt = 11'(qty) - 11'h001;

  // decode, execute, build and send the reply
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_ff     <= ST_RX;
      frame_len_ff <= 9'h000;
      bcast_ff     <= 1'b0;
      echo_ff      <= 1'b0;
      cnt_ff       <= 11'h000;
      tx_len_ff    <= 9'h000;
      tx_idx_ff    <= 9'h000;
      tx_byte_ff   <= 8'h00;
      tx_valid_ff  <= 1'b0;
      tx_done_ff   <= 1'b0;
      rd_req_ff    <= 1'b0;
      wr_req_ff    <= 1'b0;
      wr_data_ff   <= 16'h0000;
    end
    else
    begin
      tx_done_ff <= 1'b0;
      if (tx_valid_ff && tx_ready_i)
        tx_valid_ff <= 1'b0;
      case (state_ff)
        ST_RX:
        begin
          cnt_ff    <= 11'h000;
          tx_idx_ff <= 9'h000;
          if (rx_end_i && frame_ok)
          begin
            frame_len_ff <= rx_len_ff;
            bcast_ff     <= (rx_buf[0] == BCAST_ADDR);
            state_ff     <= ST_DECODE;
          end
        end
        ST_DECODE:
        begin
          tx_buf[0] <= rx_buf[0];
          tx_buf[1] <= fc;
          echo_ff   <= 1'b0;
          if (bcast_ff && (exc != EXC_NONE || fc == FC_READ_COILS || fc == FC_READ_REGS))
            state_ff <= ST_RX;
          else if (exc != EXC_NONE)
          begin
            tx_buf[1] <= fc | EXC_FLAG;
            tx_buf[2] <= exc;
            tx_len_ff <= EXC_LEN;
            state_ff  <= ST_TX;
          end
          else
          begin
            case (fc)
              FC_READ_COILS:
              begin
                tx_buf[2] <= qty_bytes[7:0];
                state_ff  <= ST_COIL_RD;
              end
              FC_WRITE_COILS: state_ff <= ST_COIL_WR;
              FC_READ_REGS:
              begin
                tx_buf[2] <= 8'(qty << 1);
                rd_req_ff <= 1'b1;
                state_ff  <= ST_REG_RD;
              end
              FC_WRITE_REG:
              begin
                wr_data_ff <= qty;
                wr_req_ff  <= 1'b1;
                state_ff   <= ST_REG_WR;
              end
              default:
              begin
                echo_ff   <= 1'b1;
                tx_len_ff <= ECHO_LEN;
                state_ff  <= bcast_ff ? ST_RX : ST_TX;
              end
            endcase
          end
        end
        ST_COIL_RD:
        begin
          tx_buf[RD_HDR_LEN + cnt_ff[7:0]] <= coil_byte;
          cnt_ff <= cnt_ff + 11'h001;
          if (cnt_ff[7:0] == qty_bytes[7:0] - 8'h01)
          begin
            tx_len_ff <= 9'(RD_HDR_LEN) + 9'(qty_bytes[7:0]);
            state_ff  <= ST_TX;
          end
        end
        ST_COIL_WR:
        begin
          cnt_ff <= cnt_ff + 11'h001;
          if (cnt_ff == last_cnt)
          begin
            echo_ff   <= 1'b1;
            tx_len_ff <= ECHO_LEN;
            state_ff  <= bcast_ff ? ST_RX : ST_TX;
          end
        end
        ST_REG_RD:
        begin
          if (par_ack_i)
          begin
            tx_buf[RD_HDR_LEN + {cnt_ff[6:0], 1'b0}]         <= par_rd_data_i[15:8];
            tx_buf[RD_HDR_LEN + {cnt_ff[6:0], 1'b0} + 8'h01] <= par_rd_data_i[7:0];
            cnt_ff <= cnt_ff + 11'h001;
            if (cnt_ff == last_cnt)
            begin
              rd_req_ff <= 1'b0;
              tx_len_ff <= 9'(RD_HDR_LEN) + {qty[7:0], 1'b0};
              state_ff  <= ST_TX;
            end
          end
        end
        ST_REG_WR:
        begin
          if (par_ack_i)
          begin
            wr_req_ff <= 1'b0;
            echo_ff   <= 1'b1;
            tx_len_ff <= ECHO_LEN;
            state_ff  <= bcast_ff ? ST_RX : ST_TX;
          end
        end
        ST_TX:
        begin
          if (send_ok)
          begin
            tx_valid_ff <= 1'b1;
            if (tx_idx_ff < tx_len_ff)
            begin
              tx_byte_ff <= tx_src;
              tx_idx_ff  <= tx_idx_ff + 9'h001;
            end
            else
            begin
              tx_byte_ff <= tx_crc.crc[7:0];
              state_ff   <= ST_TX_HI;
            end
          end
        end
        ST_TX_HI:
        begin
          if (send_ok)
          begin
            tx_valid_ff <= 1'b1;
            tx_byte_ff  <= tx_crc.crc[15:8];
            state_ff    <= ST_TX_END;
          end
        end
        ST_TX_END:
        begin
          if (tx_ready_i)
          begin
            tx_done_ff <= 1'b1;
            state_ff   <= ST_RX;
          end
        end
        default: state_ff <= ST_RX;
      endcase
    end
  end

  assign tx_byte_o  = tx_byte_ff;
  assign tx_valid_o = tx_valid_ff;
  assign tx_done_o  = tx_done_ff;
  assign rx_busy_o  = (state_ff != ST_RX);

endmodule // mbch_handler

`default_nettype wire

// *** dv/mbch_monitor.sv ***
// port checker for the modbus handler
`timescale 1ns/1ps
`default_nettype none

module mbch_monitor
  import mbch_pkg::*;
(
  // clock and reset
  input wire logic         clk_i,
  input wire logic         reset_i,
  // query and reply
  input wire logic         rx_end_i,
  input wire logic         rx_busy_o,
  input wire logic [7:0]   tx_byte_o,
  input wire logic         tx_valid_o,
  input wire logic         tx_ready_i,
  input wire logic         tx_done_o,
  // coils and parameters
  input wire logic [127:0] coils_o,
  input wire logic         nv_store_o,
  input wire logic         par_rd_req_o,
  input wire logic         par_wr_req_o,
  input wire logic         par_ack_i,
  input wire logic [15:0]  par_addr_o,
  input wire logic [15:0]  par_num_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  ////////////////////////////////
  // last crc byte taken, then the done pulse
  sequence s_last;
    tx_valid_o && tx_ready_i ##[1:2] tx_done_o;
  endsequence
  // handler back to idle
  sequence s_idle;
    !rx_busy_o && !tx_valid_o;
  endsequence

  AST_TX_HOLD:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("reply byte changed before taken");
  AST_DONE_IDLE:
    assert property (s_last |-> ##[0:2] s_idle)
    else $error("handler not idle after reply");
  AST_IDLE_QUIET:
    assert property (!rx_busy_o |-> !tx_valid_o && !par_rd_req_o && !par_wr_req_o)
    else $error("activity while not busy");
  AST_NV_COIL:
    assert property ($changed(nv_store_o) |->
      $past(rx_busy_o) && nv_store_o == coils_o[WR_CTRL_COIL])
    else $error("store select changed outside a frame or off the control coil");
  AST_PAR_NUM:
    assert property (17'(par_num_o) == (17'(par_addr_o) + 17'h1) / PARAM_STEP)
    else $error("parameter number wrong");
  AST_RD_STEP:
    assert property (par_rd_req_o && par_ack_i |=>
      !par_rd_req_o || par_addr_o == $past(par_addr_o) + 16'h1)
    else $error("read address did not step");
  AST_WR_DROP:
    assert property (par_wr_req_o && par_ack_i |=> !par_wr_req_o)
    else $error("write request held after ack");
  AST_PAR_FIRST:
    assert property (par_rd_req_o || par_wr_req_o |-> !tx_valid_o)
    else $error("reply during parameter access");
  AST_RD_START:
    assert property ($rose(par_rd_req_o) |-> $past(rx_end_i, 2) || $past(rx_end_i, 3))
    else $error("read request without a frame");
endmodule // mbch_monitor

bind mbch_handler mbch_monitor u_mon (
  .clk_i(clk_i), .reset_i(reset_i), .rx_end_i(rx_end_i),
  .rx_busy_o(rx_busy_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .tx_done_o(tx_done_o), .coils_o(coils_o),
  .nv_store_o(nv_store_o), .par_rd_req_o(par_rd_req_o),
  .par_wr_req_o(par_wr_req_o), .par_ack_i(par_ack_i),
  .par_addr_o(par_addr_o), .par_num_o(par_num_o)
);

`default_nettype wire

// *** dv/mbch_master.sv ***
// modbus master model: sends queries, takes replies
`timescale 1ns/1ps
`default_nettype none

module mbch_master
(
  // clock
  input  wire logic       clk_i,
  // query stream
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  output logic            rx_end_o,
  // reply stream
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o
);
  logic [7:0] got [$];
  bit         slow = 1'b0;

  ////////////////////////////////
  // line crc, reflected, seeded with ones
  function automatic logic [15:0] crc16(logic [87:0] f, int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++)
    begin
      c = c ^ 16'(f[8*(n-1-i)+:8]);
      repeat (8)
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction

  // fields high byte first, crc low first; bad spoils the crc
  task automatic send(logic [87:0] f, int n, bit bad);
    logic [15:0] c;
    c = crc16(f, n) ^ 16'(bad);
    for (int i = 0; i < n + 2; i++)
    begin
      @(negedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o  <= i < n ? f[8*(n-1-i)+:8] : (i == n ? c[7:0] : c[15:8]);
    end
    @(negedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~rx_byte_o;
    rx_end_o   <= 1'b1;
    @(negedge clk_i);
    rx_end_o <= 1'b0;
  endtask

  // idle levels
  initial
  begin
    rx_byte_o  = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o   = 1'b0;
    tx_ready_o = 1'b1;
  end
  // reply sink, stalls every other cycle when slow
  always @(negedge clk_i)
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  // keep accepted reply bytes
  always @(posedge clk_i)
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_byte_i);
endmodule // mbch_master

`default_nettype wire

// *** dv/tb_mbch_handler.sv ***
// self-checking bench for the modbus handler
`timescale 1ns/1ps
`default_nettype none

module tb_mbch_handler;
  logic         clk_i, rx_valid, rx_end, busy, tx_valid, tx_ready, tx_done;
  logic         nv, rd_req, wr_req;
  logic         reset_i = 1'b1;
  logic         par_ack = 1'b0;
  logic [7:0]   rx_byte, tx_byte;
  logic [15:0]  par_addr, par_num, par_wdata;
  logic [127:0] coils;
  int           num_errors = 0;
  int           n_tests = 0;
  typedef struct {
    logic [87:0] q;
    int          qn;
    bit          bad;
    logic [87:0] r;
    int          rn;
    logic        nv;
  } mbch_row_t;
  // query, length, bad crc, reply, length, store select after
  mbch_row_t rows [15] = '{
    '{88'h0105_0040_FF00, 6, 0, 88'h0105_0040_FF00, 6, 1},
    '{88'h01_0F00_1000_1002_2000, 9, 0, 88'h010F_0010_0010, 6, 1},
    '{88'h0101_0010_000A, 6, 0, 88'h01_0102_2000, 5, 1},
    '{88'h0101_003E_0002, 6, 0, 88'h0101_0100, 4, 1},
    '{88'h0101_0020_0010, 6, 0, 88'h01_0102_0706, 5, 1},
    '{88'h0103_0BD5_0002, 6, 0, 88'h01_0304_AE70_AE73, 7, 1},
    '{88'h0111, 2, 0, 88'h01_9101, 3, 1},
    '{88'h0105_0040_1234, 6, 0, 88'h01_8503, 3, 1},
    '{88'h0705_0040_0000, 6, 0, 88'h0, 0, 1},
    '{88'h0105_0040_0000, 6, 1, 88'h0, 0, 1},
    '{88'h0001_0040_0001, 6, 0, 88'h0, 0, 1},
    '{88'h0005_0040_0000, 6, 0, 88'h0, 0, 0},
    '{88'h0101_0040_0001, 6, 0, 88'h0101_0100, 4, 0},
    '{88'h0101_007F_0002, 6, 0, 88'h01_8102, 3, 0},
    '{88'h0106_03E7_0001, 6, 0, 88'h0106_03E7_0001, 6, 0}
  };

  ////////////////////////////////
  mbch_handler DUT (
    .clk_i(clk_i), .reset_i(reset_i), .own_addr_i(8'h01),
    .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_end_i(rx_end),
    .rx_busy_o(busy), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .tx_done_o(tx_done),
    .drive_status_word_i(16'h0607), .coils_o(coils), .nv_store_o(nv),
    .par_rd_req_o(rd_req), .par_wr_req_o(wr_req), .par_addr_o(par_addr),
    .par_num_o(par_num), .par_wr_data_o(par_wdata), .par_ack_i(par_ack),
    .par_rd_data_i(par_addr ^ 16'hA5A5)
  );
  mbch_master mst (
    .clk_i(clk_i), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .rx_end_o(rx_end), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready)
  );

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // parameter side answers every other cycle while asked
  always @(negedge clk_i)
    par_ack <= (rd_req || wr_req) && !par_ack;

  ////////////////////////////////
  task automatic fail(string m);
    num_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // port value against expectation
  task automatic chk_val(logic [131:0] g, logic [131:0] x);
    n_tests++;
    if (g !== x)
      fail($sformatf("port value %0h, want %0h", g, x));
  endtask

  // collected reply against bytes plus crc
  task automatic chk_reply(logic [87:0] r, int n);
    logic [15:0] c;
    logic [7:0]  e [$];
    bit          ok;
    c = mst.crc16(r, n);
    for (int i = 0; i < n; i++)
      e.push_back(r[8*(n-1-i)+:8]);
    if (n > 0)
    begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    ok = mst.got.size() == e.size();
    foreach (e[i])
      if (ok && mst.got[i] !== e[i])
        ok = 0;
    n_tests++;
    if (!ok)
      fail("reply bytes differ");
  endtask

  // wait until the frame is handled, bounded
  task automatic wait_idle;
    int k;
    k = 0;
    repeat (3) @(negedge clk_i);
    while (busy !== 1'b0 && k < 400)
    begin
      @(negedge clk_i);
      k++;
    end
    if (k == 400)
      fail("handler stuck busy");
  endtask

  ////////////////////////////////
  // reset, table of frames, then hand-written cases
  initial
  begin
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    foreach (rows[i])
    begin
      mst.slow = i[0];
      mst.got.delete();
      mst.send(rows[i].q, rows[i].qn, rows[i].bad);
      wait_idle();
      chk_reply(rows[i].r, rows[i].rn);
      chk_val(132'(nv), 132'(rows[i].nv));
      $display("row %0d done", i);
    end
    chk_val(132'({par_addr, par_num, par_wdata}), 132'h03E7_0064_0001);
    // a frame sent while busy is dropped
    mst.slow = 1'b1;
    mst.got.delete();
    mst.send(88'h0105_0000_FF00, 6, 1'b0);
    mst.send(88'h0105_0001_FF00, 6, 1'b0);
    wait_idle();
    chk_reply(88'h0105_0000_FF00, 6);
    chk_val(132'(coils[1:0]), 132'h1);
    $display("busy drop done");
    // mid-run reset clears the coil image
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_val({coils, nv, busy, tx_valid, tx_done}, 132'h0);
    reset_i = 1'b0;
    // first frame right after release sees a cleared image
    mst.got.delete();
    mst.send(88'h0101_0000_0008, 6, 1'b0);
    wait_idle();
    chk_reply(88'h0101_0100, 4);
    $display("reset done");
    end_sim();
  end

  // cut a hang short
  initial
  begin
    #200000;
    fail("timeout");
    end_sim();
  end
endmodule // tb_mbch_handler

`default_nettype wire
